// ==== shared/nmos_pkg.sv ====
// Constants, types and step ROM for the multiplane NAND host sequencer.
// Assumes a 25 MHz core clock and an 8-bit multiplexed NAND device on the pins.
package nmos_pkg;
  localparam int CLK_NS = 40;
  localparam int WB_NS  = 100;
  localparam int RD_NS  = 160;
  localparam logic [2:0] WB_CNT = 3'((WB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] RD_CNT = 3'((RD_NS + CLK_NS - 1) / CLK_NS);

  localparam int PLANE_ROW_BIT        = 6;
  localparam logic [7:0] PLANE_BYTE_MASK = 8'h40;
  localparam int STAT_READY_BIT       = 6;
  localparam logic [2:0] PART_MAX     = 3'h4;

  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_READ_GO   = 8'h30;
  localparam logic [7:0] CMD_CB_READ   = 8'h35;
  localparam logic [7:0] CMD_PROG      = 8'h80;
  localparam logic [7:0] CMD_PROG_MP   = 8'h11;
  localparam logic [7:0] CMD_PROG_NEXT = 8'h81;
  localparam logic [7:0] CMD_PROG_GO   = 8'h10;
  localparam logic [7:0] CMD_CB_PROG   = 8'h85;
  localparam logic [7:0] CMD_ERASE     = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_STATUS_EN = 8'h78;
  localparam logic [7:0] CMD_RESET     = 8'hFF;

  // Address step flags
  localparam int AB_PLANE  = 3;
  localparam int AB_TARGET = 4;
  localparam int AB_FORCE  = 5;
  localparam int AB_ROW    = 6;

  typedef enum logic [2:0] {OP_RESET, OP_STATUS, OP_READ, OP_PROG, OP_ERASE, OP_COPY} nmos_op_t;
  typedef enum logic [2:0] {K_CMD, K_ADDR, K_WDATA, K_RDATA, K_WAIT, K_POLL, K_STAT, K_END} nmos_kind_t;

  typedef struct packed {
    nmos_kind_t  kind;
    logic [7:0]  val;
  } nmos_step_t;

  typedef struct packed {
    nmos_op_t    op;
    logic [15:0] col;
    logic [23:0] row;
    logic [23:0] row_t;
    logic [11:0] len_m1;
  } nmos_req_t;

  typedef struct packed {
    logic       rd;
    logic       cle;
    logic       ale;
    logic [7:0] data;
  } nmos_cyc_t;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       wp_n;
    logic [7:0] io_out;
    logic       io_oe;
  } nmos_pins_t;

  localparam logic [5:0] SEQ_START [0:5] = '{6'h00, 6'h03, 6'h06, 6'h0E, 6'h1B, 6'h24};

  localparam nmos_step_t SEQ_ROM [0:54] = '{
    // Reset
    '{K_CMD, CMD_RESET}, '{K_WAIT, 8'h00}, '{K_END, 8'h00},
    // Status
    '{K_CMD, CMD_STATUS}, '{K_STAT, 8'h00}, '{K_END, 8'h00},
    // Page read, polled, then 00h again before data
    '{K_CMD, CMD_READ}, '{K_ADDR, 8'h00}, '{K_CMD, CMD_READ_GO}, '{K_CMD, CMD_STATUS},
    '{K_POLL, 8'h00}, '{K_CMD, CMD_READ}, '{K_RDATA, 8'h00}, '{K_END, 8'h00},
    // Multiplane program
    '{K_CMD, CMD_PROG}, '{K_ADDR, 8'h20}, '{K_WDATA, 8'h00}, '{K_CMD, CMD_PROG_MP}, '{K_WAIT, 8'h00},
    '{K_CMD, CMD_PROG_NEXT}, '{K_ADDR, 8'h28}, '{K_WDATA, 8'h00}, '{K_CMD, CMD_PROG_GO},
    '{K_WAIT, 8'h00}, '{K_CMD, CMD_STATUS}, '{K_STAT, 8'h00}, '{K_END, 8'h00},
    // Multiplane erase
    '{K_CMD, CMD_ERASE}, '{K_ADDR, 8'h60}, '{K_CMD, CMD_ERASE}, '{K_ADDR, 8'h68},
    '{K_CMD, CMD_ERASE_GO}, '{K_WAIT, 8'h00}, '{K_CMD, CMD_STATUS}, '{K_STAT, 8'h00}, '{K_END, 8'h00},
    // Multiplane copy back
    '{K_CMD, CMD_READ}, '{K_ADDR, 8'h20}, '{K_CMD, CMD_CB_READ}, '{K_WAIT, 8'h00},
    '{K_CMD, CMD_READ}, '{K_ADDR, 8'h28}, '{K_CMD, CMD_CB_READ}, '{K_WAIT, 8'h00},
    '{K_CMD, CMD_CB_PROG}, '{K_ADDR, 8'h30}, '{K_CMD, CMD_PROG_MP}, '{K_WAIT, 8'h00},
    '{K_CMD, CMD_PROG_NEXT}, '{K_ADDR, 8'h38}, '{K_CMD, CMD_PROG_GO}, '{K_WAIT, 8'h00},
    '{K_CMD, CMD_STATUS}, '{K_STAT, 8'h00}, '{K_END, 8'h00}
  };
endpackage

// ==== hdl/nmos_bus_cycle.sv ====
// One NAND bus cycle: command, address or data write, or data read.
// Assumes the caller starts a cycle only while done is low and the engine is idle.
`timescale 1ns/1ps
module nmos_bus_cycle (
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire logic                 go,
  input  wire nmos_pkg::nmos_cyc_t  cyc,
  input  wire logic [7:0]           io_in,
  output logic                      done,
  output logic [7:0]                rdata,
  output logic                      cle,
  output logic                      ale,
  output logic                      we_n,
  output logic                      re_n,
  output logic [7:0]                io_out,
  output logic                      io_oe
);
  typedef enum logic [3:0] {E_IDLE = 4'b0001, E_SET = 4'b0010, E_LOW = 4'b0100, E_HOLD = 4'b1000} nmos_eng_t;

  nmos_eng_t  state_reg, state_next;
  logic       rd_reg, rd_next;
  logic [2:0] cnt_reg, cnt_next;
  logic       cle_reg, cle_next, ale_reg, ale_next;
  logic       we_n_reg, we_n_next, re_n_reg, re_n_next;
  logic [7:0] io_out_reg, io_out_next;
  logic       io_oe_reg, io_oe_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] io_s1_reg, io_s1_next, io_s2_reg, io_s2_next;

  localparam logic [2:0] RD_CNT_M1 = nmos_pkg::RD_CNT - 3'h1;

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  always_comb begin
    state_next  = state_reg;
    rd_next     = rd_reg;
    cnt_next    = cnt_reg;
    cle_next    = cle_reg;
    ale_next    = ale_reg;
    we_n_next   = we_n_reg;
    re_n_next   = re_n_reg;
    io_out_next = io_out_reg;
    io_oe_next  = io_oe_reg;
    rdata_next  = rdata_reg;
    io_s1_next  = io_in;
    io_s2_next  = io_s1_reg;
    case (state_reg)
      E_IDLE: begin
        if (go) begin
          cle_next    = cyc.cle;
          ale_next    = cyc.ale;
          io_out_next = cyc.data;
          io_oe_next  = !cyc.rd;
          rd_next     = cyc.rd;
          state_next  = E_SET;
        end
      end
      E_SET: begin
        if (rd_reg) begin
          re_n_next = 1'b0;
        end else begin
          we_n_next = 1'b0;
        end
        cnt_next   = 3'h0;
        state_next = E_LOW;
      end
      E_LOW: begin
        if (rd_reg && cnt_reg != RD_CNT_M1) begin
          cnt_next = cnt_reg + 3'h1;
        end else begin
          we_n_next  = 1'b1;
          re_n_next  = 1'b1;
          if (rd_reg) begin
            rdata_next = io_s2_reg;
          end
          state_next = E_HOLD;
        end
      end
      E_HOLD: begin
        state_next = E_IDLE;
      end
      default: begin
        state_next = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg  <= E_IDLE;
      rd_reg     <= 1'b0;
      cnt_reg    <= 3'h0;
      cle_reg    <= 1'b0;
      ale_reg    <= 1'b0;
      we_n_reg   <= 1'b1;
      re_n_reg   <= 1'b1;
      io_out_reg <= 8'h00;
      io_oe_reg  <= 1'b0;
      rdata_reg  <= 8'h00;
      io_s1_reg  <= 8'h00;
      io_s2_reg  <= 8'h00;
    end else begin
      state_reg  <= state_next;
      rd_reg     <= rd_next;
      cnt_reg    <= cnt_next;
      cle_reg    <= cle_next;
      ale_reg    <= ale_next;
      we_n_reg   <= we_n_next;
      re_n_reg   <= re_n_next;
      io_out_reg <= io_out_next;
      io_oe_reg  <= io_oe_next;
      rdata_reg  <= rdata_next;
      io_s1_reg  <= io_s1_next;
      io_s2_reg  <= io_s2_next;
    end
  end

  assign done   = (state_reg == E_HOLD);
  assign rdata  = rdata_reg;
  assign cle    = cle_reg;
  assign ale    = ale_reg;
  assign we_n   = we_n_reg;
  assign re_n   = re_n_reg;
  assign io_out = io_out_reg;
  assign io_oe  = io_oe_reg;

  read_low_a: assert property ($fell(re_n_reg) |-> !re_n_reg [*4] ##1 re_n_reg) else $error("read strobe width wrong");
  write_low_a: assert property ($fell(we_n_reg) |=> we_n_reg && !io_oe_reg == 1'b0) else $error("write strobe not one cycle");
endmodule

// ==== hdl/nmos_host.sv ====
// Host-side sequencer that drives a multiplane NAND device over its pins.
// Assumes ready_busy_n and io_in come straight from pins; the user port is on core_clk.
`timescale 1ns/1ps
module nmos_host (
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire nmos_pkg::nmos_req_t  req,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  output logic                      refused,
  input  wire logic [7:0]           wr_data,
  input  wire logic                 wr_valid,
  output logic                      wr_ready,
  output logic [7:0]                rd_data,
  output logic                      rd_valid,
  output logic [7:0]                status,
  output logic                      done,
  output logic                      init_done,
  input  wire logic                 wp_hold,
  input  wire logic [7:0]           io_in,
  input  wire logic                 ready_busy_n,
  output nmos_pkg::nmos_pins_t      pins
);
  typedef enum logic [5:0] {
    ST_PWR = 6'b000001, ST_IDLE = 6'b000010, ST_STEP = 6'b000100,
    ST_CYC = 6'b001000, ST_WB = 6'b010000, ST_RB = 6'b100000
  } nmos_state_t;

  nmos_state_t         state_reg, state_next;
  nmos_pkg::nmos_req_t req_reg, req_next;
  logic [5:0]          pc_reg, pc_next;
  logic [11:0]         sub_reg, sub_next;
  logic [2:0]          cnt_reg, cnt_next;
  logic [7:0]          status_reg, status_next, rd_data_reg, rd_data_next;
  logic                rd_valid_reg, rd_valid_next, done_reg, done_next;
  logic                refused_reg, refused_next, init_done_reg, init_done_next;
  logic                ce_n_reg, ce_n_next, wp_n_reg, wp_n_next;
  logic [23:0]         part_row_reg, part_row_next;
  logic [2:0]          part_cnt_reg, part_cnt_next;
  logic                rb_s1_reg, rb_s1_next, rb_s2_reg, rb_s2_next;

  nmos_pkg::nmos_step_t step;
  nmos_pkg::nmos_cyc_t  cyc;
  logic                 go, eng_done, eng_cle, eng_ale, eng_we_n, eng_re_n, eng_io_oe;
  logic [7:0]           eng_rdata, eng_io_out, addr_byte;
  logic [2:0]           eff_idx;
  logic [23:0]          row_sel;
  logic                 same_page, last_unit;

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  assign step      = nmos_pkg::SEQ_ROM[pc_reg];
  assign eff_idx   = sub_reg[2:0] + (step.val[nmos_pkg::AB_ROW] ? 3'h2 : 3'h0);
  assign last_unit = (sub_reg == req_reg.len_m1);
  assign same_page = (req.row == part_row_reg);

  // Plane bit forced per step so both rows differ only there, source and target alike
  always_comb begin
    row_sel = step.val[nmos_pkg::AB_TARGET] ? req_reg.row_t : req_reg.row;
    if (step.val[nmos_pkg::AB_FORCE]) begin
      row_sel[nmos_pkg::PLANE_ROW_BIT] = step.val[nmos_pkg::AB_PLANE];
    end
    case (eff_idx)
      3'h0:    addr_byte = req_reg.col[7:0];
      3'h1:    addr_byte = req_reg.col[15:8];
      3'h2:    addr_byte = row_sel[7:0];
      3'h3:    addr_byte = row_sel[15:8];
      default: addr_byte = row_sel[23:16];
    endcase
  end

  always_comb begin
    state_next     = state_reg;
    req_next       = req_reg;
    pc_next        = pc_reg;
    sub_next       = sub_reg;
    cnt_next       = cnt_reg;
    status_next    = status_reg;
    rd_data_next   = rd_data_reg;
    rd_valid_next  = 1'b0;
    done_next      = 1'b0;
    refused_next   = 1'b0;
    init_done_next = init_done_reg;
    ce_n_next      = ce_n_reg;
    wp_n_next      = init_done_reg && !wp_hold;
    part_row_next  = part_row_reg;
    part_cnt_next  = part_cnt_reg;
    rb_s1_next     = ready_busy_n;
    rb_s2_next     = rb_s1_reg;
    go             = 1'b0;
    wr_ready       = 1'b0;
    cyc            = '{rd: 1'b0, cle: 1'b0, ale: 1'b0, data: 8'h00};
    case (state_reg)
      ST_PWR: begin
        if (rb_s2_reg) begin
          req_next.op = nmos_pkg::OP_RESET;
          pc_next     = nmos_pkg::SEQ_START[nmos_pkg::OP_RESET];
          ce_n_next   = 1'b0;
          state_next  = ST_STEP;
        end
      end
      ST_IDLE: begin
        if (req_valid) begin
          if (req.op == nmos_pkg::OP_PROG && same_page && part_cnt_reg == nmos_pkg::PART_MAX) begin
            refused_next = 1'b1;
          end else begin
            req_next   = req;
            pc_next    = nmos_pkg::SEQ_START[req.op];
            sub_next   = 12'h000;
            ce_n_next  = 1'b0;
            state_next = ST_STEP;
            if (req.op == nmos_pkg::OP_PROG) begin
              part_row_next = req.row;
              part_cnt_next = same_page ? part_cnt_reg + 3'h1 : 3'h1;
            end else if (req.op == nmos_pkg::OP_ERASE) begin
              part_cnt_next = 3'h0;
            end
          end
        end
      end
      ST_STEP: begin
        case (step.kind)
          nmos_pkg::K_CMD: begin
            go         = 1'b1;
            cyc        = '{rd: 1'b0, cle: 1'b1, ale: 1'b0, data: step.val};
            state_next = ST_CYC;
          end
          nmos_pkg::K_ADDR: begin
            go         = 1'b1;
            cyc        = '{rd: 1'b0, cle: 1'b0, ale: 1'b1, data: addr_byte};
            state_next = ST_CYC;
          end
          nmos_pkg::K_WDATA: begin
            wr_ready = 1'b1;
            if (wr_valid) begin
              go         = 1'b1;
              ce_n_next  = 1'b0;
              cyc        = '{rd: 1'b0, cle: 1'b0, ale: 1'b0, data: wr_data};
              state_next = ST_CYC;
            end else begin
              ce_n_next = 1'b1;
            end
          end
          nmos_pkg::K_RDATA, nmos_pkg::K_POLL, nmos_pkg::K_STAT: begin
            go         = 1'b1;
            cyc        = '{rd: 1'b1, cle: 1'b0, ale: 1'b0, data: 8'h00};
            state_next = ST_CYC;
          end
          nmos_pkg::K_WAIT: begin
            cnt_next   = 3'h0;
            state_next = ST_WB;
          end
          default: begin
            done_next      = 1'b1;
            init_done_next = 1'b1;
            ce_n_next      = 1'b1;
            state_next     = ST_IDLE;
          end
        endcase
      end
      ST_CYC: begin
        if (eng_done) begin
          state_next = ST_STEP;
          case (step.kind)
            nmos_pkg::K_ADDR: begin
              if (eff_idx == 3'h4) begin
                pc_next  = pc_reg + 6'h01;
                sub_next = 12'h000;
              end else begin
                sub_next = sub_reg + 12'h001;
              end
            end
            nmos_pkg::K_WDATA, nmos_pkg::K_RDATA: begin
              if (step.kind == nmos_pkg::K_RDATA) begin
                rd_data_next  = eng_rdata;
                rd_valid_next = 1'b1;
              end
              if (last_unit) begin
                pc_next  = pc_reg + 6'h01;
                sub_next = 12'h000;
              end else begin
                sub_next = sub_reg + 12'h001;
              end
            end
            nmos_pkg::K_POLL: begin
              if (eng_rdata[nmos_pkg::STAT_READY_BIT]) begin
                pc_next = pc_reg + 6'h01;
              end
            end
            nmos_pkg::K_STAT: begin
              status_next = eng_rdata;
              pc_next     = pc_reg + 6'h01;
            end
            default: begin
              pc_next = pc_reg + 6'h01;
            end
          endcase
        end
      end
      ST_WB: begin
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == nmos_pkg::WB_CNT) begin
          state_next = ST_RB;
        end
      end
      ST_RB: begin
        if (rb_s2_reg) begin
          pc_next    = pc_reg + 6'h01;
          state_next = ST_STEP;
        end
      end
      default: begin
        state_next = ST_PWR;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg     <= ST_PWR;
      req_reg       <= '0;
      pc_reg        <= 6'h00;
      sub_reg       <= 12'h000;
      cnt_reg       <= 3'h0;
      status_reg    <= 8'h00;
      rd_data_reg   <= 8'h00;
      rd_valid_reg  <= 1'b0;
      done_reg      <= 1'b0;
      refused_reg   <= 1'b0;
      init_done_reg <= 1'b0;
      ce_n_reg      <= 1'b1;
      wp_n_reg      <= 1'b0;
      part_row_reg  <= 24'h000000;
      part_cnt_reg  <= 3'h0;
      rb_s1_reg     <= 1'b0;
      rb_s2_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      req_reg       <= req_next;
      pc_reg        <= pc_next;
      sub_reg       <= sub_next;
      cnt_reg       <= cnt_next;
      status_reg    <= status_next;
      rd_data_reg   <= rd_data_next;
      rd_valid_reg  <= rd_valid_next;
      done_reg      <= done_next;
      refused_reg   <= refused_next;
      init_done_reg <= init_done_next;
      ce_n_reg      <= ce_n_next;
      wp_n_reg      <= wp_n_next;
      part_row_reg  <= part_row_next;
      part_cnt_reg  <= part_cnt_next;
      rb_s1_reg     <= rb_s1_next;
      rb_s2_reg     <= rb_s2_next;
    end
  end

  nmos_bus_cycle u_cycle (
    .core_clk (core_clk),
    .srst     (srst),
    .go       (go),
    .cyc      (cyc),
    .io_in    (io_in),
    .done     (eng_done),
    .rdata    (eng_rdata),
    .cle      (eng_cle),
    .ale      (eng_ale),
    .we_n     (eng_we_n),
    .re_n     (eng_re_n),
    .io_out   (eng_io_out),
    .io_oe    (eng_io_oe)
  );

  assign pins      = '{ce_n: ce_n_reg, cle: eng_cle, ale: eng_ale, we_n: eng_we_n, re_n: eng_re_n,
                       wp_n: wp_n_reg, io_out: eng_io_out, io_oe: eng_io_oe};
  assign req_ready = (state_reg == ST_IDLE);
  assign refused   = refused_reg;
  assign rd_data   = rd_data_reg;
  assign rd_valid  = rd_valid_reg;
  assign status    = status_reg;
  assign done      = done_reg;
  assign init_done = init_done_reg;

  // Checking helpers: last command, multiplane gap, address byte run, plane A row byte
  logic [7:0] last_cmd_q, r1a_q;
  logic       gap_q;
  logic [2:0] addr_n_q;
  logic       cyc_end;
  assign cyc_end = (state_reg == ST_CYC) && eng_done;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      last_cmd_q <= 8'h00;
      r1a_q      <= 8'h00;
      gap_q      <= 1'b0;
      addr_n_q   <= 3'h0;
    end else if (cyc_end && step.kind == nmos_pkg::K_CMD) begin
      last_cmd_q <= step.val;
      addr_n_q   <= 3'h0;
      if (step.val == nmos_pkg::CMD_PROG_MP) begin
        gap_q <= 1'b1;
      end else if (step.val == nmos_pkg::CMD_PROG_NEXT) begin
        gap_q <= 1'b0;
      end
    end else if (cyc_end && step.kind == nmos_pkg::K_ADDR) begin
      addr_n_q <= addr_n_q + 3'h1;
      if (eff_idx == 3'h2 && !step.val[nmos_pkg::AB_PLANE]) begin
        r1a_q <= eng_io_out;
      end
    end
  end

  cmd_pins_a: assert property ($rose(pins.we_n) && pins.cle |-> !pins.ale && pins.re_n && !pins.ce_n)
    else $error("command latched with wrong pin levels");
  first_reset_a: assert property ($rose(pins.we_n) && pins.cle && !init_done_reg |-> pins.io_out == 8'hFF)
    else $error("first command after power-on not reset");
  wp_init_a: assert property (!init_done_reg |-> !pins.wp_n)
    else $error("write-protect released before init");
  mp_gap_a: assert property ($rose(pins.we_n) && pins.cle && gap_q |-> pins.io_out inside {8'h70, 8'h78, 8'hFF, 8'h81})
    else $error("illegal command inside multiplane gap");
  addr_count_a: assert property ($rose(pins.we_n) && pins.cle |-> addr_n_q inside {3'h0, 3'h3, 3'h5})
    else $error("address byte count wrong");
  plane_pair_a: assert property ($rose(pins.we_n) && pins.ale && step.kind == nmos_pkg::K_ADDR && eff_idx == 3'h2
                                 && step.val[nmos_pkg::AB_FORCE] && step.val[nmos_pkg::AB_PLANE]
                                 |-> (pins.io_out ^ r1a_q) == nmos_pkg::PLANE_BYTE_MASK)
    else $error("second plane row differs beyond plane bit");
  read_reissue_a: assert property ($fell(pins.re_n) && step.kind == nmos_pkg::K_RDATA |-> last_cmd_q == 8'h00)
    else $error("data read without fresh 00h");
  part_limit_a: assert property (state_reg == ST_IDLE && req_valid && req.op == nmos_pkg::OP_PROG && same_page
                                 && part_cnt_reg == nmos_pkg::PART_MAX |=> refused && state_reg == ST_IDLE)
    else $error("fifth partial program not refused");
  busy_cmds_a: assert property ($rose(pins.we_n) && pins.cle && state_reg == ST_CYC && !rb_s2_reg && init_done_reg
                                |-> pins.io_out inside {8'h70, 8'h78, 8'hFF})
    else $error("array command while busy");
  ce_gap_a: assert property (state_reg == ST_STEP && step.kind == nmos_pkg::K_WDATA && !wr_valid
                             |=> pins.ce_n ##1 pins.ce_n || state_reg != ST_STEP)
    else $error("chip select not released on data stall");
endmodule

// ==== tb/nmos_flash_model.sv ====
// Behavioural NAND device at the host pins.
// Assumes pins move on core_clk; busy time counted in core_clk cycles.
`timescale 1ns/1ps
module nmos_flash_model #(
  parameter bit PROT_ALL = 1'b0
) (
  input  wire logic                 core_clk,
  input  wire nmos_pkg::nmos_pins_t pins,
  input  wire logic                 erase_fail,
  output logic [7:0]                io_in,
  output logic                      ready_busy_n
);
  logic [9:0] log_q[$];
  logic [7:0] cmd_last = 8'h00;
  logic [7:0] io_last = 8'h00;
  logic [7:0] rd_cnt = 8'h00;
  logic [1:0] fail = 2'b00;
  logic       rd_stat = 1'b0;
  logic       started = 1'b0;
  int         busy = 0;
  int         bad = 0;
  wire  [7:0] c = pins.io_out;
  assign ready_busy_n = (busy == 0);
  // Released bus shows the inverse of the last byte
  assign io_in = (!pins.ce_n && !pins.re_n) ? io_last : ~io_last;
  always @(posedge core_clk) if (busy > 0) busy--;
  always @(negedge pins.re_n) begin
    if (!pins.ce_n) begin
      io_last = rd_stat ? {pins.wp_n, (busy == 0), 4'h0, fail} : rd_cnt;
      if (!rd_stat) rd_cnt++;
    end
  end
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.re_n) log_q.push_back({pins.cle, pins.ale, c});
    if (!pins.ce_n && pins.re_n && pins.cle && !pins.ale) begin
      if (!started && c != 8'hFF) bad++;
      if (busy > 0 && !(c inside {8'h70, 8'h78, 8'hFF})) bad++;
      if (cmd_last == 8'h11 && !(c inside {8'h70, 8'h78, 8'hFF, 8'h81})) bad++;
      started = 1'b1;
      rd_stat = (c == 8'h70);
      if (c == 8'h00) rd_cnt = 8'hA5;
      if (c inside {8'h10, 8'h11, 8'h30, 8'h35, 8'hD0, 8'hFF}) busy = 12;
      if (c inside {8'h10, 8'hD0}) fail = (PROT_ALL || !pins.wp_n) ? 2'b01 : {2{erase_fail && c == 8'hD0}};
      if (!(c inside {8'h70, 8'h78})) cmd_last = c;
    end
  end
endmodule

// ==== tb/tb_nmos_host.sv ====
// Bench for the NAND host sequencer.
// Assumes the device model is compiled first.
`timescale 1ns/1ps
module tb_nmos_host;
  nmos_pkg::nmos_req_t  req = '0;
  nmos_pkg::nmos_pins_t pins;
  logic       core_clk = 1'b0;
  logic       srst = 1'b1;
  logic       req_valid = 1'b0;
  logic       wr_valid = 1'b0;
  logic       wp_hold = 1'b0;
  logic       erase_fail = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic       req_ready, refused, wr_ready, rd_valid, done, init_done, ready_busy_n;
  logic [7:0] rd_data, status, io_in;
  logic [7:0] got[$];
  int         miscompares = 0;
  int         comparisons = 0;
  always #20 core_clk = ~core_clk;
  nmos_host DUT (.core_clk, .srst, .req, .req_valid, .req_ready, .refused, .wr_data, .wr_valid, .wr_ready,
    .rd_data, .rd_valid, .status, .done, .init_done, .wp_hold, .io_in, .ready_busy_n, .pins);
  nmos_flash_model m (.core_clk, .pins, .erase_fail, .io_in, .ready_busy_n);
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmp_log(input int s, input logic [9:0] e[$]);
    for (int i = 0; i < e.size(); i++) check("pin cycle", m.log_q[s + i], e[i]);
  endtask
  task automatic run_op(input nmos_pkg::nmos_op_t op, input logic [23:0] row, input logic [11:0] len_m1);
    int n;
    got.delete();
    for (n = 0; n < 99 && req_ready !== 1'b1; n++) @(posedge core_clk);
    if (n == 99) begin
      miscompares++;
      report_and_stop();
    end
    req <= '{op, 16'h0123, row, 24'h000100, len_m1};
    req_valid <= 1'b1;
    wr_data <= 8'hB0;
    @(posedge core_clk);
    req_valid <= 1'b0;
    for (n = 0; n < 4000 && done !== 1'b1 && refused !== 1'b1; n++) begin
      @(posedge core_clk);
      if (wr_ready === 1'b1 && wr_valid === 1'b1) wr_data <= wr_data + 8'h01;
      // Data held back at first so chip select is released mid-load
      if (n == 40) wr_valid <= 1'b1;
      if (rd_valid === 1'b1) got.push_back(rd_data);
    end
    wr_valid <= 1'b0;
    if (n == 4000) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic sc_program();
    int s = m.log_q.size();
    for (int i = 0; i < 5; i++) begin
      run_op(nmos_pkg::OP_PROG, 24'h0456C7, 12'h001);
      check("refused", 10'(refused), (i == 4) ? 10'h001 : 10'h000);
    end
    cmp_log(s, '{10'h280, 10'h123, 10'h101, 10'h187, 10'h156, 10'h104, 10'h0B0, 10'h0B1, 10'h211, 10'h281,
      10'h123, 10'h101, 10'h1C7, 10'h156, 10'h104, 10'h0B2, 10'h0B3, 10'h210, 10'h270});
  endtask
  task automatic sc_erase();
    int s = m.log_q.size();
    for (int i = 0; i < 2; i++) begin
      erase_fail <= (i == 0);
      run_op(nmos_pkg::OP_ERASE, 24'h0456C7, 12'h000);
      check("plane fail", 10'(status[1]), (i == 0) ? 10'h001 : 10'h000);
    end
    cmp_log(s, '{10'h260, 10'h187, 10'h156, 10'h104, 10'h260, 10'h1C7, 10'h156, 10'h104, 10'h2D0});
  endtask
  task automatic sc_read();
    run_op(nmos_pkg::OP_READ, 24'h000200, 12'h002);
    check("read count", 10'(got.size()), 10'h003);
    for (int i = 0; i < 3; i++) check("read byte", 10'(got[i]), 10'(8'hA5 + i));
    check("last command", m.log_q[m.log_q.size() - 1], 10'h200);
  endtask
  task automatic sc_protect();
    int s;
    wp_hold <= 1'b1;
    run_op(nmos_pkg::OP_PROG, 24'h000800, 12'h000);
    check("wp pin", 10'(pins.wp_n), 10'h000);
    check("wp status", 10'(status[7]), 10'h000);
    wp_hold <= 1'b0;
    s = m.log_q.size();
    run_op(nmos_pkg::OP_COPY, 24'h000040, 12'h000);
    cmp_log(s, '{10'h200, 10'h123, 10'h101, 10'h100, 10'h100, 10'h100, 10'h235, 10'h200, 10'h123, 10'h101,
      10'h140, 10'h100, 10'h100, 10'h235, 10'h285, 10'h123, 10'h101, 10'h100, 10'h101, 10'h100, 10'h211,
      10'h281, 10'h123, 10'h101, 10'h140, 10'h101, 10'h100, 10'h210, 10'h270});
    check("copy status", 10'(status[0]), 10'h000);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    check("wp in reset", 10'(pins.wp_n), 10'h000);
    srst <= 1'b0;
    for (int n = 0; n < 999 && init_done !== 1'b1; n++) @(posedge core_clk);
    if (init_done !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    check("first command", m.log_q[0], 10'h2FF);
    sc_program();
    sc_erase();
    sc_read();
    sc_protect();
    check("model faults", 10'(m.bad), 10'h000);
    report_and_stop();
  end
endmodule
